// ### shared/acw_pkg.sv
package acw_pkg;
	// control word layout
	localparam int WORD_W = 12;
	localparam int POWER_HI_BIT = 11;
	localparam int POWER_LO_BIT = 10;
	localparam int CODING_BIT = 9;
	localparam int REFSRC_BIT = 8;
	localparam int ZERO_BIT = 7;
	localparam int CHAN_HI_BIT = 6;
	localparam int CHAN_LO_BIT = 5;
	localparam int CFG_HI_BIT = 4;
	localparam int CFG_LO_BIT = 3;
	localparam int SCAN_HI_BIT = 2;
	localparam int SCAN_LO_BIT = 1;
	localparam int RANGE_BIT = 0;
	localparam logic [11:0] WORD_RESET = 12'h000;
	// power codes
	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_AUTO_SHUT = 2'h1;
	localparam logic [1:0] PWR_AUTO_STBY = 2'h2;
	localparam logic [1:0] PWR_FULL_SHUT = 2'h3;
	// input configuration codes
	localparam logic [1:0] CFG_SINGLE = 2'h0;
	localparam logic [1:0] CFG_DIFF = 2'h1;
	localparam logic [1:0] CFG_PSEUDO = 2'h2;
	localparam logic [1:0] CFG_UNUSED = 2'h3;
	// negative mux select: 0..3 analog inputs, 4 analog ground
	localparam logic [2:0] NEG_GROUND = 3'h4;
	// wake from standby
	localparam int WAKE_NS = 1000;
	localparam int CLK_NS = 10;
	localparam int WAKE_CYCLES = WAKE_NS / CLK_NS;
	typedef enum {
		ACW_ON,
		ACW_STANDBY,
		ACW_SHUTDOWN,
		ACW_WAKING
	} acw_power_type;
endpackage : acw_pkg

// ### shared/acw_mux_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acw_mux_if;
	logic [1:0] chan;
	logic [1:0] cfg;
	logic [1:0] posSel;
	logic [2:0] negSel;
	modport ctl (output chan, output cfg, input posSel, input negSel);
	modport dec (input chan, input cfg, output posSel, output negSel);
endinterface : acw_mux_if
`default_nettype wire

// ### rtl/acw_mux_decode.sv
`timescale 1ns/1ps
`default_nettype none
module acw_mux_decode
	import acw_pkg::*;
(
	acw_mux_if.dec mux
);
	// paired modes swap within a pair: partner is address with bit 0 flipped
	wire logic [1:0] pairPartner;
	assign pairPartner = {mux.chan[1], ~mux.chan[0]};
	assign mux.posSel = mux.chan;
	assign mux.negSel = (mux.cfg == CFG_SINGLE) ? NEG_GROUND :
		{1'b0, pairPartner};
endmodule : acw_mux_decode
`default_nettype wire

// ### rtl/acw_control_word.sv
// Operation
// - power request from bits 11 and 10
// - bit 9 picks binary or twos complement
// - bit 8 one selects internal reference
// - sequencer off, bits 6:5 pick channel
// - sequencer on, bits 6:5 last channel
// - bits 4:3 choose input configuration
// - bits 2:1 decide sequencer activity
// - bit 0 selects one or two reference span
// - code 00 keeps everything powered
// - code 01 shuts down after conversion
// - code 10 standby, wake within 1 us
// - code 11 shuts down, word kept
// - single-ended: channel positive, ground negative
// - differential pairs 01,10,23,32
// - pseudo-differential uses same pairs
// - twelve-bit word, write only
// - chip select with write strobe loads
// - word clears to zero at power-up
// - scan from 0 to last, skip inverses
`timescale 1ns/1ps
`default_nettype none
module acw_control_word
	import acw_pkg::*;
#(
	parameter int WAKE_COUNT = WAKE_CYCLES
)(
	input wire logic clk,
	input wire logic reset,
	input wire logic selectN,
	input wire logic writeN,
	input wire logic [11:0] dataIn,
	input wire logic convStart,
	input wire logic convDone,
	output logic twosComplement,
	output logic internalRef,
	output logic doubleRange,
	output logic scanActive,
	output logic [1:0] inputCfg,
	output logic [1:0] posSel,
	output logic [2:0] negSel,
	output logic powerUp,
	output logic standby,
	output logic ready
);
	logic [11:0] controlWord;
	logic [1:0] curChan;
	logic [6:0] wakeCount;
	acw_power_type powerState;
	acw_power_type next_powerState;
	acw_mux_if mux();

	// write decode; bits beyond the word are never read back
	wire logic writeHit;
	wire logic [1:0] powerCode;
	wire logic [1:0] chanAddr;
	wire logic scanOn;
	wire logic [1:0] stepChan;
	wire logic stepWrap;
	assign writeHit = !selectN && !writeN;
	assign powerCode = {controlWord[POWER_HI_BIT],
		controlWord[POWER_LO_BIT]};
	assign chanAddr = {controlWord[CHAN_HI_BIT],
		controlWord[CHAN_LO_BIT]};
	// mixed codes are unused; treat them as sequencer off
	assign scanOn = controlWord[SCAN_HI_BIT] &&
		controlWord[SCAN_LO_BIT];
	// paired modes step by two so inverse pairs are skipped
	assign stepChan = (inputCfg == CFG_SINGLE) ? curChan + 2'h1 :
		curChan + 2'h2;
	assign stepWrap = (curChan >= chanAddr) ||
		(inputCfg != CFG_SINGLE && stepChan > chanAddr);

	// single register, so every field changes on the same edge
	always_ff @(posedge clk) begin
		if (reset) begin
			controlWord <= WORD_RESET;
		end else if (writeHit) begin
			controlWord <= dataIn;
		end
	end

	// channel in use: written address, or running scan position
	always_ff @(posedge clk) begin
		if (reset) begin
			curChan <= 2'h0;
		end else if (writeHit) begin
			curChan <= (dataIn[SCAN_HI_BIT] && dataIn[SCAN_LO_BIT]) ?
				2'h0 : {dataIn[CHAN_HI_BIT], dataIn[CHAN_LO_BIT]};
		end else if (scanOn && convStart) begin
			curChan <= stepWrap ? 2'h0 : stepChan;
		end
	end

	// decoded static fields and registered mux selects
	always_ff @(posedge clk) begin
		if (reset) begin
			twosComplement <= 1'b0;
			internalRef <= 1'b0;
			doubleRange <= 1'b0;
			scanActive <= 1'b0;
			inputCfg <= CFG_SINGLE;
			posSel <= 2'h0;
			negSel <= NEG_GROUND;
		end else begin
			twosComplement <= controlWord[CODING_BIT];
			internalRef <= controlWord[REFSRC_BIT];
			doubleRange <= controlWord[RANGE_BIT];
			scanActive <= scanOn;
			inputCfg <= {controlWord[CFG_HI_BIT],
				controlWord[CFG_LO_BIT]};
			posSel <= mux.posSel;
			negSel <= mux.negSel;
		end
	end

	assign mux.chan = curChan;
	assign mux.cfg = inputCfg;
	acw_mux_decode decoder (
		.mux(mux)
	);

	// power state; conversion request wakes standby, and wakes shutdown only in code 01
	always_comb begin
		next_powerState = powerState;
		case (powerState)
			ACW_ON: begin
				if (powerCode == PWR_FULL_SHUT)
					next_powerState = ACW_SHUTDOWN;
				else if (powerCode == PWR_AUTO_SHUT && convDone)
					next_powerState = ACW_SHUTDOWN;
				else if (powerCode == PWR_AUTO_STBY && convDone)
					next_powerState = ACW_STANDBY;
			end
			ACW_STANDBY, ACW_SHUTDOWN: begin
				// full shutdown wins over any wake request
				if (powerCode == PWR_FULL_SHUT)
					next_powerState = ACW_SHUTDOWN;
				else if (powerCode == PWR_NORMAL)
					next_powerState = ACW_ON;
				else if (powerState == ACW_STANDBY && convStart)
					next_powerState = ACW_WAKING;
				else if (powerCode == PWR_AUTO_SHUT && convStart)
					next_powerState = ACW_ON;
				else if (powerCode == PWR_AUTO_STBY)
					next_powerState = ACW_STANDBY;
			end
			ACW_WAKING: begin
				// a full-shutdown or normal mode word overrides an unfinished wake
				if (powerCode == PWR_FULL_SHUT)
					next_powerState = ACW_SHUTDOWN;
				else if (powerCode == PWR_NORMAL ||
					wakeCount == 7'(WAKE_COUNT - 1))
					next_powerState = ACW_ON;
			end
			default: next_powerState = ACW_ON;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			powerState <= ACW_ON;
			wakeCount <= 7'h00;
		end else begin
			powerState <= next_powerState;
			wakeCount <= (powerState == ACW_WAKING) ?
				wakeCount + 7'h01 : 7'h00;
		end
	end

	// registered power outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			powerUp <= 1'b1;
			standby <= 1'b0;
			ready <= 1'b1;
		end else begin
			powerUp <= (next_powerState == ACW_ON) ||
				(next_powerState == ACW_WAKING);
			standby <= next_powerState == ACW_STANDBY;
			ready <= next_powerState == ACW_ON;
		end
	end

	// capture, field decode and power sequencing checks
	chk_word_capture: assert property (
		@(posedge clk) disable iff (reset)
		writeHit |=> controlWord == $past(dataIn))
		else $error("control word not captured");
	chk_word_hold: assert property (
		@(posedge clk) disable iff (reset)
		!writeHit |=> $stable(controlWord))
		else $error("control word changed without write");
	chk_coding_out: assert property (
		@(posedge clk) disable iff (reset)
		writeHit ##1 !writeHit
		|=> twosComplement == $past(dataIn[CODING_BIT], 2))
		else $error("coding output wrong");
	// judged against the written data, not the stored word
	chk_ref_out: assert property (
		@(posedge clk) disable iff (reset)
		writeHit
		|-> ##2 internalRef == $past(dataIn[REFSRC_BIT], 2))
		else $error("reference select wrong");
	chk_single_ground: assert property (
		@(posedge clk) disable iff (reset)
		inputCfg == CFG_SINGLE |-> mux.negSel == NEG_GROUND)
		else $error("single-ended negative not ground");
	chk_pair_map: assert property (
		@(posedge clk) disable iff (reset)
		inputCfg != CFG_SINGLE
		|-> mux.negSel == {1'b0, curChan ^ 2'h1})
		else $error("pair mapping wrong");
	chk_normal_on: assert property (
		@(posedge clk) disable iff (reset)
		powerCode == PWR_NORMAL ##1 powerCode == PWR_NORMAL
		|-> ##1 powerState == ACW_ON)
		else $error("normal mode not powered");
	chk_wake_time: assert property (
		@(posedge clk) disable iff (reset)
		$rose(powerState == ACW_WAKING)
		|-> ##[1:100] powerState != ACW_WAKING)
		else $error("standby wake too slow");
	chk_auto_shut: assert property (
		@(posedge clk) disable iff (reset)
		powerState == ACW_ON && powerCode == PWR_AUTO_SHUT && convDone
		|=> powerState == ACW_SHUTDOWN)
		else $error("auto shutdown missed");
	// holds from every state, waking and standby included
	chk_full_shut: assert property (
		@(posedge clk) disable iff (reset)
		powerCode == PWR_FULL_SHUT |=> powerState == ACW_SHUTDOWN)
		else $error("full shutdown missed");
endmodule : acw_control_word
`default_nettype wire

// ### verification/acw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acw_host_model (
	input wire logic clk,
	output logic selectN,
	output logic writeN,
	output logic [11:0] dataIn
);
	// idle bus: nothing selected
	initial begin
		selectN = 1'b1;
		writeN = 1'b1;
		dataIn = 12'h000;
	end
	// one word per call; spare bit cleared, mode 11 folded to 01
	task automatic write_word(input logic [11:0] w);
		@(posedge clk);
		selectN <= 1'b0;
		writeN <= 1'b0;
		dataIn <= {w[11:8], 1'b0, w[6:5], w[4] & ~w[3], w[3:0]};
		@(posedge clk);
		selectN <= 1'b1;
		writeN <= 1'b1;
		// released bus must not keep showing the word
		dataIn <= ~w;
	endtask : write_word
endmodule : acw_host_model
`default_nettype wire

// ### verification/test_adc_control_word_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_word_decode;
	import acw_pkg::*;
	logic clk, reset, selectN, writeN, convStart, convDone;
	logic twosComplement, internalRef, doubleRange, scanActive;
	logic powerUp, standby, ready;
	logic [1:0] inputCfg, posSel;
	logic [2:0] negSel;
	logic [11:0] dataIn;
	logic [10:0] fieldsNow;
	int fails, checkCount;
	// short wake count keeps the standby test quick
	localparam int WAKE_SIM = 4;
	// packed views of the outputs for comparison
	assign fieldsNow = {twosComplement, internalRef, doubleRange, scanActive,
		inputCfg, posSel, negSel};
	acw_host_model host (.clk(clk), .selectN(selectN), .writeN(writeN),
		.dataIn(dataIn));
	acw_control_word #(.WAKE_COUNT(WAKE_SIM)) dut (.clk(clk), .reset(reset),
		.selectN(selectN), .writeN(writeN), .dataIn(dataIn),
		.convStart(convStart), .convDone(convDone),
		.twosComplement(twosComplement), .internalRef(internalRef),
		.doubleRange(doubleRange), .scanActive(scanActive),
		.inputCfg(inputCfg), .posSel(posSel), .negSel(negSel),
		.powerUp(powerUp), .standby(standby), .ready(ready));
	// free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [10:0] got, input logic [10:0] exp);
		checkCount++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// expected fields; negative side ground only in single-ended use
	function automatic logic [10:0] exp_fields(input logic [11:0] w);
		return {w[9], w[8], w[0], w[2] & w[1], w[4:3], w[6:5],
			(w[4:3] == 2'h0) ? NEG_GROUND : {1'b0, w[6], ~w[5]}};
	endfunction : exp_fields
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic pulse(input logic isDone);
		@(posedge clk);
		if (isDone) convDone <= 1'b1;
		else convStart <= 1'b1;
		@(posedge clk);
		convDone <= 1'b0;
		convStart <= 1'b0;
	endtask : pulse
	task automatic check_power(input logic [2:0] exp);
		check({8'h00, powerUp, standby, ready}, {8'h00, exp});
	endtask : check_power
	task automatic test_reset();
		settle(1);
		check(fieldsNow, {8'h00, NEG_GROUND});
		check_power(3'h5);
		$display("test reset done");
	endtask : test_reset
	// reset in mid-run returns word and outputs to power-up values
	task automatic test_midreset();
		host.write_word(12'h309);
		settle(4);
		check(fieldsNow, exp_fields(12'h309));
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		settle(1);
		check(fieldsNow, {8'h00, NEG_GROUND});
		check_power(3'h5);
		$display("test midreset done");
	endtask : test_midreset
	// every mode, coding, reference and range, mixed scan code 10 off
	task automatic test_fields();
		logic [11:0] words[8] = '{12'h200, 12'h100, 12'h001, 12'h060,
			12'h048, 12'h030, 12'h068, 12'h016};
		foreach (words[i]) begin
			host.write_word(words[i]);
			settle(4);
			check(fieldsNow, exp_fields(words[i]));
		end
		host.write_word(12'h002);
		host.write_word(12'h004);
		settle(4);
		check(fieldsNow, exp_fields(12'h004));
		$display("test fields done");
	endtask : test_fields
	// single-ended scan to channel 2 wraps to 0
	task automatic test_scan();
		logic [1:0] seq[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
		host.write_word(12'h046);
		foreach (seq[i]) begin
			if (i > 0) pulse(1'b0);
			settle(3);
			check({9'h000, posSel}, {9'h000, seq[i]});
		end
		check({10'h000, scanActive}, 11'h001);
		$display("test scan done");
	endtask : test_scan
	task automatic test_power();
		int n;
		host.write_word(12'h400);
		settle(4);
		pulse(1'b1);
		settle(1);
		check_power(3'h0);
		pulse(1'b0);
		settle(1);
		check_power(3'h5);
		host.write_word(12'h800);
		settle(4);
		pulse(1'b1);
		settle(1);
		check_power(3'h2);
		pulse(1'b0);
		settle(1);
		check_power(3'h4);
		// waking must end within the shortened wake count
		n = 0;
		while (ready !== 1'b1 && n < 10) begin
			settle(1);
			n++;
		end
		// ready rises WAKE_SIM edges after the start; loop began one late
		check(11'(n), 11'(WAKE_SIM - 1));
		host.write_word(12'hF09);
		settle(4);
		check_power(3'h0);
		check(fieldsNow, exp_fields(12'hF09));
		host.write_word(12'h000);
		settle(4);
		check_power(3'h5);
		$display("test power done");
	endtask : test_power
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : give_verdict
	// main sequence
	initial begin
		fails = 0;
		checkCount = 0;
		reset = 1'b1;
		convStart = 1'b0;
		convDone = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_fields();
		test_scan();
		test_power();
		test_midreset();
		give_verdict();
	end
endmodule : test_adc_control_word_decode
`default_nettype wire
